// *** pkg/tws_pkg.sv ***
// Constants shared by the two-wire status flag block
package tws_pkg;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  // Register byte offsets
  localparam logic [7:0] OFF_STATUS   = 8'h00;
  localparam logic [7:0] OFF_RECEIVE  = 8'h04;
  localparam logic [7:0] OFF_TRANSMIT = 8'h08;
  localparam logic [7:0] OFF_IRQ_STAT = 8'h0C;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h10;
  // Status register field positions
  localparam int unsigned BIT_WCOL  = 7;
  localparam int unsigned BIT_OVF   = 6;
  localparam int unsigned BIT_STOP  = 4;
  localparam int unsigned BIT_START = 3;
  localparam int unsigned BIT_RW    = 2;
  localparam int unsigned BIT_RBF   = 1;
  localparam int unsigned BIT_TBF   = 0;
  // Interrupt event positions
  localparam int unsigned EV_W       = 6;
  localparam int unsigned EV_RX      = 0;
  localparam int unsigned EV_TXDONE  = 1;
  localparam int unsigned EV_STOP    = 2;
  localparam int unsigned EV_START   = 3;
  localparam int unsigned EV_OVF     = 4;
  localparam int unsigned EV_WCOL    = 5;
  // Reset values and bus answers
  localparam logic [5:0]  MASK_RESET = 6'h00;
  localparam logic [1:0]  RESP_OKAY  = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;
endpackage

// *** logic/tws_sticky.sv ***
// Sticky event bits, set wins over clear
`timescale 1ns/1ps
module tws_sticky #(
  parameter int unsigned WIDTH = 1
) (
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic [WIDTH-1:0] set,
  input  wire logic [WIDTH-1:0] clr,
  output logic      [WIDTH-1:0] q
);
  typedef struct packed {
    logic [WIDTH-1:0] bits;
  } tws_sticky_t;

  tws_sticky_t s;
  tws_sticky_t next_s;

  always_comb
  begin
    next_s = s;
    // Clear first so a simultaneous event survives
    next_s.bits = (s.bits & ~clr) | set;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      s <= '0;
    else
      s <= next_s;
  end

  assign q = s.bits;
endmodule // tws_sticky

// *** logic/tws_status.sv ***
// Two-wire controller status flags with AXI4-Lite register slave
// Operation
// - Stop sets stop-last; start clears it
// - Start sets start-last; stop clears it
// - Slave address byte updates direction flag
// - Received byte sets receive-holding-full
// - Reading receive holding register clears full
// - Writing transmit holding register sets full
// - Transmission done clears transmit-holding-full
// - Byte arriving while full sets sticky overflow
// - Transmit write while busy: rejected, collision set
`timescale 1ns/1ps
module tws_status
  import tws_pkg::*;
(
  input  wire logic                       aclk,
  input  wire logic                       aresetn,
  input  wire logic [tws_pkg::ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                       s_axi_awvalid,
  output logic                            s_axi_awready,
  input  wire logic [tws_pkg::DATA_W-1:0] s_axi_wdata,
  input  wire logic [3:0]                 s_axi_wstrb,
  input  wire logic                       s_axi_wvalid,
  output logic                            s_axi_wready,
  output logic [1:0]                      s_axi_bresp,
  output logic                            s_axi_bvalid,
  input  wire logic                       s_axi_bready,
  input  wire logic [tws_pkg::ADDR_W-1:0] s_axi_araddr,
  input  wire logic                       s_axi_arvalid,
  output logic                            s_axi_arready,
  output logic [tws_pkg::DATA_W-1:0]      s_axi_rdata,
  output logic [1:0]                      s_axi_rresp,
  output logic                            s_axi_rvalid,
  input  wire logic                       s_axi_rready,
  input  wire logic                       start_det,
  input  wire logic                       stop_det,
  input  wire logic                       slave_mode,
  input  wire logic                       addr_rcvd,
  input  wire logic                       addr_rw,
  input  wire logic                       byte_rcvd,
  input  wire logic [7:0]                 rx_data,
  input  wire logic                       tx_done,
  input  wire logic                       engine_busy,
  output logic [7:0]                      tx_data,
  output logic                            tx_load,
  output logic                            irq
);
  typedef struct packed {
    logic                aw_held;
    logic [ADDR_W-1:0]   aw_addr;
    logic                w_held;
    logic [7:0]          w_data;
    logic                w_strb0;
    logic                bvalid;
    logic [1:0]          bresp;
    logic                rvalid;
    logic [DATA_W-1:0]   rdata;
    logic [1:0]          rresp;
    logic                write_collision_flag;
    logic                receive_overflow_flag;
    logic                stop_last;
    logic                start_last;
    logic                rw;
    logic                receive_holding_full;
    logic                transmit_holding_full;
    logic [7:0]          receive_holding_register;
    logic [7:0]          transmit_holding_register;
    logic                tx_load;
    logic [EV_W-1:0]     mask;
  } tws_state_t;

  tws_state_t s;
  tws_state_t next_s;

  logic            ar_fire;
  logic            do_write;
  logic            wr_en;
  logic            wr_status;
  logic            wr_trn;
  logic            wr_mask;
  logic            trn_busy;
  logic            rd_rcv;
  logic            rd_irq;
  logic            ovf_event;
  logic            wcol_event;
  logic            rx_load;
  logic [EV_W-1:0] ev_set;
  logic [EV_W-1:0] ev_clr;
  logic [EV_W-1:0] irq_stat;
  logic [7:0]      status_byte;

  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] off);
    hit = (a[ADDR_W-1:2] == off[7:2]);
  endfunction

  assign s_axi_awready = !s.aw_held && !s.bvalid;
  assign s_axi_wready  = !s.w_held && !s.bvalid;
  assign s_axi_arready = !s.rvalid;
  assign ar_fire       = s_axi_arvalid && s_axi_arready;
  assign do_write      = s.aw_held && s.w_held && !s.bvalid;
  // Only byte lane 0 carries defined bits
  assign wr_en         = do_write && s.w_strb0;
  assign wr_status     = wr_en && hit(s.aw_addr, OFF_STATUS);
  assign wr_trn        = wr_en && hit(s.aw_addr, OFF_TRANSMIT);
  assign wr_mask       = wr_en && hit(s.aw_addr, OFF_IRQ_MASK);
  assign rd_rcv        = ar_fire && hit(s_axi_araddr, OFF_RECEIVE);
  assign rd_irq        = ar_fire && hit(s_axi_araddr, OFF_IRQ_STAT);
  // Busy covers a held byte and any engine activity
  assign trn_busy      = s.transmit_holding_full || engine_busy;
  assign wcol_event    = wr_trn && trn_busy;
  // A read in the same cycle frees the holder for the new byte
  assign ovf_event     = byte_rcvd && s.receive_holding_full && !rd_rcv;
  assign rx_load       = byte_rcvd && !ovf_event;

  assign status_byte = {s.write_collision_flag, s.receive_overflow_flag, 1'b0,
                        s.stop_last, s.start_last, s.rw,
                        s.receive_holding_full, s.transmit_holding_full};

  assign ev_set[EV_RX]     = rx_load;
  assign ev_set[EV_TXDONE] = tx_done && s.transmit_holding_full;
  assign ev_set[EV_STOP]   = stop_det;
  assign ev_set[EV_START]  = start_det;
  assign ev_set[EV_OVF]    = ovf_event;
  assign ev_set[EV_WCOL]   = wcol_event;
  assign ev_clr            = rd_irq ? {EV_W{1'b1}} : {EV_W{1'b0}};

  tws_sticky #(
    .WIDTH (EV_W)
  ) u_irq_stat (
    .aclk    (aclk),
    .aresetn (aresetn),
    .set     (ev_set),
    .clr     (ev_clr),
    .q       (irq_stat)
  );

  always_comb
  begin
    next_s = s;
    next_s.tx_load = 1'b0;
    // Write address and data are taken independently
    if (s_axi_awvalid && s_axi_awready)
    begin
      next_s.aw_held = 1'b1;
      next_s.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      next_s.w_held  = 1'b1;
      next_s.w_data  = s_axi_wdata[7:0];
      next_s.w_strb0 = s_axi_wstrb[0];
    end
    if (s.bvalid && s_axi_bready)
      next_s.bvalid = 1'b0;
    if (do_write)
    begin
      next_s.aw_held = 1'b0;
      next_s.w_held  = 1'b0;
      next_s.bvalid  = 1'b1;
      if (hit(s.aw_addr, OFF_STATUS) || hit(s.aw_addr, OFF_RECEIVE)
          || hit(s.aw_addr, OFF_TRANSMIT) || hit(s.aw_addr, OFF_IRQ_STAT)
          || hit(s.aw_addr, OFF_IRQ_MASK))
        next_s.bresp = RESP_OKAY;
      else
        next_s.bresp = RESP_SLVERR;
    end
    if (s.rvalid && s_axi_rready)
      next_s.rvalid = 1'b0;
    if (ar_fire)
    begin
      next_s.rvalid = 1'b1;
      next_s.rresp  = RESP_OKAY;
      if (hit(s_axi_araddr, OFF_STATUS))
        next_s.rdata = {24'h000000, status_byte};
      else if (hit(s_axi_araddr, OFF_RECEIVE))
        next_s.rdata = {24'h000000, s.receive_holding_register};
      else if (hit(s_axi_araddr, OFF_TRANSMIT))
        next_s.rdata = {24'h000000, s.transmit_holding_register};
      else if (hit(s_axi_araddr, OFF_IRQ_STAT))
        next_s.rdata = {26'h0000000, irq_stat};
      else if (hit(s_axi_araddr, OFF_IRQ_MASK))
        next_s.rdata = {26'h0000000, s.mask};
      else
      begin
        next_s.rdata = 32'h00000000;
        next_s.rresp = RESP_SLVERR;
      end
    end
    if (wr_mask)
      next_s.mask = s.w_data[EV_W-1:0];
    // Software may only clear the two error flags, write one to clear
    if (wr_status && s.w_data[BIT_WCOL])
      next_s.write_collision_flag = 1'b0;
    if (wr_status && s.w_data[BIT_OVF])
      next_s.receive_overflow_flag = 1'b0;
    if (start_det)
    begin
      next_s.start_last = 1'b1;
      next_s.stop_last  = 1'b0;
    end
    // Stop is the later condition when both strobe together
    if (stop_det)
    begin
      next_s.stop_last  = 1'b1;
      next_s.start_last = 1'b0;
    end
    if (addr_rcvd && slave_mode)
      next_s.rw = addr_rw;
    if (rd_rcv)
      next_s.receive_holding_full = 1'b0;
    if (rx_load)
    begin
      next_s.receive_holding_register = rx_data;
      next_s.receive_holding_full     = 1'b1;
    end
    // Unread byte is kept; the new one is dropped
    if (ovf_event)
      next_s.receive_overflow_flag = 1'b1;
    if (tx_done)
      next_s.transmit_holding_full = 1'b0;
    if (wcol_event)
      next_s.write_collision_flag = 1'b1;
    else if (wr_trn)
    begin
      next_s.transmit_holding_register = s.w_data;
      next_s.transmit_holding_full     = 1'b1;
      next_s.tx_load                   = 1'b1;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s      <= '0;
      s.mask <= MASK_RESET;
    end
    else
      s <= next_s;
  end

  assign s_axi_bvalid = s.bvalid;
  assign s_axi_bresp  = s.bresp;
  assign s_axi_rvalid = s.rvalid;
  assign s_axi_rdata  = s.rdata;
  assign s_axi_rresp  = s.rresp;
  assign tx_data      = s.transmit_holding_register;
  assign tx_load      = s.tx_load;
  assign irq          = |(irq_stat & s.mask);

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_trn_accept;
    wr_trn && !trn_busy;
  endsequence

  sequence s_trn_loaded;
    s.transmit_holding_full && s.tx_load ##1 !s.tx_load;
  endsequence

  sequence s_status_quiet;
    wr_status && !start_det && !stop_det && !addr_rcvd;
  endsequence

  a_stop_last_set: assert property (
    stop_det |=> s.stop_last && !s.start_last)
    else $error("stop did not set stop-last");

  a_start_last_set: assert property (
    start_det && !stop_det |=> s.start_last && !s.stop_last)
    else $error("start did not set start-last");

  a_dir_update: assert property (
    addr_rcvd && slave_mode |=> s.rw == $past(addr_rw))
    else $error("direction flag not taken from address byte");

  a_rx_full_set: assert property (
    byte_rcvd && (!s.receive_holding_full || rd_rcv)
    |=> s.receive_holding_full && s.receive_holding_register == $past(rx_data))
    else $error("received byte not loaded");

  a_rx_read_clear: assert property (
    rd_rcv && !byte_rcvd |=> !s.receive_holding_full)
    else $error("receive read did not empty holder");

  a_tx_full_set: assert property (
    s_trn_accept |=> s_trn_loaded)
    else $error("transmit write did not set full");

  a_tx_done_clear: assert property (
    tx_done && !wr_trn |=> !s.transmit_holding_full)
    else $error("transmit done did not clear full");

  a_overflow_sticky: assert property (
    ovf_event |=> s.receive_overflow_flag && $stable(s.receive_holding_register)
    ##1 (s.receive_overflow_flag || $past(wr_status)))
    else $error("overflow flag lost or holder overwritten");

  a_wcol_reject: assert property (
    wr_trn && trn_busy |=> s.write_collision_flag && !s.tx_load
    && $stable(s.transmit_holding_register))
    else $error("busy transmit write not rejected");

  a_hw_flag_guard: assert property (
    s_status_quiet |=> $stable(s.start_last) && $stable(s.stop_last) && $stable(s.rw))
    else $error("status write altered hardware flag");

  a_read_answer: assert property (
    ar_fire && hit(s_axi_araddr, OFF_RECEIVE)
    |=> s_axi_rvalid && s_axi_rdata == {24'h000000, $past(s.receive_holding_register)})
    else $error("receive read answer wrong");

  a_irq_level: assert property (
    ev_set[EV_RX] && s.mask[EV_RX] && !rd_irq && !wr_mask |=> irq)
    else $error("unmasked event did not raise interrupt");
endmodule // tws_status

// *** testbench/tws_engine_model.sv ***
// Two-wire engine stand-in: condition, address, byte and done strobes
`timescale 1ns/1ps
module tws_engine_model (
  input  wire logic aclk,
  output logic      start_det,
  output logic      stop_det,
  output logic      slave_mode,
  output logic      addr_rcvd,
  output logic      addr_rw,
  output logic      byte_rcvd,
  output logic [7:0] rx_data,
  output logic      tx_done,
  output logic      engine_busy
);
  initial
  begin
    {start_det, stop_det, slave_mode, addr_rcvd, addr_rw} = 5'h00;
    {byte_rcvd, tx_done, engine_busy} = 3'h0;
    rx_data = 8'h00;
  end
  // One-cycle strobe after lag idle cycles; data inverted afterwards so stale data is never valid
  task automatic strobe(input int k, input logic [7:0] d, input int lag);
    repeat (lag) @(posedge aclk);
    @(posedge aclk);
    start_det <= (k == 0);
    stop_det <= (k == 1);
    addr_rcvd <= (k == 2);
    byte_rcvd <= (k == 3);
    tx_done <= (k == 4);
    rx_data <= d;
    addr_rw <= d[0];
    @(posedge aclk);
    {start_det, stop_det, addr_rcvd, byte_rcvd, tx_done} <= 5'h00;
    rx_data <= ~d;
    addr_rw <= ~d[0];
  endtask
endmodule // tws_engine_model

// *** testbench/testbench.sv ***
// Self-checking bench for the two-wire status flag block
`timescale 1ns/1ps
module testbench;
  import tws_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, tx_data;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
  logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, tx_load, irq, start_det, stop_det, slave_mode, addr_rcvd;
  logic addr_rw, byte_rcvd, tx_done, engine_busy;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic [7:0] rx_data;
  logic [31:0] rd;
  int failures = 0;
  int checks_done = 0;
  int tx_loads = 0;
  localparam logic [31:0] ST_STOP = 32'h1 << BIT_STOP;
  localparam logic [31:0] ST_START = 32'h1 << BIT_START;
  localparam logic [31:0] ST_RW = 32'h1 << BIT_RW;
  localparam logic [31:0] ST_RBF = 32'h1 << BIT_RBF;
  localparam logic [31:0] ST_TBF = 32'h1 << BIT_TBF;
  localparam logic [31:0] ST_OVF = 32'h1 << BIT_OVF;
  localparam logic [31:0] ST_WCOL = 32'h1 << BIT_WCOL;

  always #2 aclk = ~aclk;

  // One-cycle load pulses are counted so no task has to catch them
  always @(posedge aclk)
    if (tx_load === 1'b1)
      tx_loads <= tx_loads + 1;

  tws_status dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .start_det, .stop_det,
    .slave_mode, .addr_rcvd, .addr_rw, .byte_rcvd, .rx_data, .tx_done, .engine_busy,
    .tx_data, .tx_load, .irq);
  tws_engine_model eng (.aclk, .start_det, .stop_det, .slave_mode, .addr_rcvd,
    .addr_rw, .byte_rcvd, .rx_data, .tx_done, .engine_busy);

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp)
    begin
      failures++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic hung();
    failures++;
    report_and_stop();
  endtask

  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    bit pa = 1, pw = 1, got = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    for (int n = 0; n < 50 && (pa || pw); n++)
    begin
      @(posedge aclk);
      if (pa && s_axi_awready)
      begin
        pa = 0;
        s_axi_awvalid <= 0;
      end
      if (pw && s_axi_wready)
      begin
        pw = 0;
        s_axi_wvalid <= 0;
      end
    end
    for (int n = 0; n < 50 && !got && !pa && !pw; n++)
    begin
      if (n > 0 || s_axi_bvalid !== 1'b1)
        @(posedge aclk);
      if (s_axi_bvalid === 1'b1)
      begin
        got = 1;
        resp = s_axi_bresp;
        s_axi_bready <= 0;
      end
    end
    if (!got)
      hung();
  endtask

  task automatic axr(input logic [7:0] a);
    bit got = 0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    for (int n = 0; n < 50 && !got; n++)
    begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready)
        s_axi_arvalid <= 0;
      if (s_axi_rvalid === 1'b1)
      begin
        got = 1;
        rd = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 0;
      end
    end
    if (!got)
      hung();
  endtask

  task automatic st(input logic [31:0] exp);
    axr(OFF_STATUS);
    chk("status", exp, rd);
  endtask

  task automatic sc_reset();
    st(32'h0);
    axr(OFF_IRQ_MASK);
    chk("mask", 32'h0, rd);
    axr(8'h20);
    chk("unmapped rresp", {30'h0, RESP_SLVERR}, {30'h0, resp});
    axw(8'h20, 32'hFF);
    chk("unmapped bresp", {30'h0, RESP_SLVERR}, {30'h0, resp});
  endtask

  task automatic sc_cond();
    eng.strobe(0, 8'h00, 0);
    st(ST_START);
    eng.strobe(1, 8'h00, 0);
    st(ST_STOP);
  endtask

  task automatic sc_dir();
    eng.slave_mode <= 1;
    eng.strobe(2, 8'h01, 0);
    st(ST_STOP | ST_RW);
    eng.strobe(2, 8'h00, 0);
    st(ST_STOP);
    eng.slave_mode <= 0;
    eng.strobe(2, 8'h01, 0);
    st(ST_STOP);
  endtask

  task automatic sc_rx();
    axw(OFF_IRQ_MASK, 32'h1 << EV_RX);
    axr(OFF_IRQ_STAT);
    chk("irq status cond", (32'h1 << EV_STOP) | (32'h1 << EV_START), rd);
    eng.strobe(3, 8'hA5, 0);
    st(ST_STOP | ST_RBF);
    chk("irq", 32'h1, {31'h0, irq});
    eng.strobe(3, 8'h3C, 0);
    st(ST_STOP | ST_RBF | ST_OVF);
    axr(OFF_RECEIVE);
    chk("receive", 32'hA5, rd);
    st(ST_STOP | ST_OVF);
    axw(OFF_STATUS, 32'hFF);
    st(ST_STOP);
    axr(OFF_IRQ_STAT);
    chk("irq status", (32'h1 << EV_RX) | (32'h1 << EV_OVF), rd);
    chk("irq cleared", 32'h0, {31'h0, irq});
    axw(OFF_IRQ_MASK, 32'h0);
    eng.strobe(3, 8'h66, 0);
    // Status bit lands one edge after the strobe
    @(posedge aclk);
    chk("irq masked", 32'h0, {31'h0, irq});
    axr(OFF_RECEIVE);
    chk("receive", 32'h66, rd);
  endtask

  task automatic sc_tx();
    axw(OFF_TRANSMIT, 32'h5A);
    st(ST_STOP | ST_TBF);
    axw(OFF_TRANSMIT, 32'h11);
    st(ST_STOP | ST_TBF | ST_WCOL);
    chk("tx_data", 32'h5A, {24'h0, tx_data});
    chk("tx_load count", 32'h1, tx_loads);
    axw(OFF_STATUS, ST_WCOL);
    eng.strobe(4, 8'h00, 5);
    st(ST_STOP);
    eng.engine_busy <= 1;
    axw(OFF_TRANSMIT, 32'h22);
    st(ST_STOP | ST_WCOL);
    eng.engine_busy <= 0;
    axw(OFF_STATUS, ST_WCOL);
    axw(OFF_TRANSMIT, 32'h33);
    st(ST_STOP | ST_TBF);
    chk("tx_data", 32'h33, {24'h0, tx_data});
    chk("tx_load count", 32'h2, tx_loads);
    axr(OFF_IRQ_STAT);
    chk("irq status tx", (32'h1 << EV_RX) | (32'h1 << EV_TXDONE) | (32'h1 << EV_WCOL), rd);
  endtask

  task automatic sc_mid_reset();
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    st(32'h0);
    chk("tx_data reset", 32'h0, {24'h0, tx_data});
  endtask

  initial
  begin
    repeat (12) @(posedge aclk);
    aresetn <= 1;
    sc_reset();
    sc_cond();
    sc_dir();
    sc_rx();
    sc_tx();
    sc_mid_reset();
    report_and_stop();
  end
endmodule // testbench
